// file: verilog/rtc_i2c_pkg.sv
// constants and state encoding shared by the rtc two-wire slave port
package rtc_i2c_pkg;
   localparam logic [6:0] SLAVE_ADDR      = 7'h32;
   localparam logic [3:0] PTR_AFTER_STOP  = 4'hf;
   localparam logic [3:0] FMT_READ_NOW    = 4'h4;
   localparam logic [7:0] TIMEOUT_FILL    = 8'hff;
   localparam logic [3:0] BYTE_BITS       = 4'h8;
   localparam logic [3:0] LAST_TX_BIT     = 4'h7;
   localparam int         TICK_PERIOD_MS  = 500;
   localparam int         TIMEOUT_MIN_MS  = 500;
   localparam logic [1:0] TIMEOUT_TICKS   = 2'(TIMEOUT_MIN_MS / TICK_PERIOD_MS + 1);
   localparam int         WR_W            = 12;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_ADDR     = 3'h1,
      ST_ADDR_ACK = 3'h3,
      ST_RX       = 3'h2,
      ST_RX_ACK   = 3'h6,
      ST_TX       = 3'h7,
      ST_TX_ACK   = 3'h5,
      ST_IGNORE   = 3'h4
   } link_state_e;
endpackage

// file: verilog/pair_buffer.sv
// two-entry buffer with valid/ready on both sides; head word is a register
`timescale 1ns/1ps
module pair_buffer #(
   parameter int W = 12
) (
   input  wire logic         sys_clk_in,
   input  wire logic         arst_n_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out
);
   logic [W-1:0] tail;
   logic         tail_v;
   logic         push;
   logic         pop;

   assign in_ready_out = !tail_v;
   assign push         = in_valid_in && !tail_v;
   assign pop          = out_valid_out && out_ready_in;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         out_data_out  <= '0;
         out_valid_out <= 1'b0;
         tail          <= '0;
         tail_v        <= 1'b0;
      end else begin
         unique case ({push, pop})
            2'b10: begin
               if (!out_valid_out) begin
                  out_data_out  <= in_data_in;
                  out_valid_out <= 1'b1;
               end else begin
                  tail   <= in_data_in;
                  tail_v <= 1'b1;
               end
            end
            2'b01: begin
               out_data_out  <= tail;
               out_valid_out <= tail_v;
               tail_v        <= 1'b0;
            end
            // push with pop only happens while the tail is empty
            2'b11: out_data_out <= in_data_in;
            default: ;
         endcase
      end
   end
endmodule

// file: verilog/rtc_i2c_slave.sv
// two-wire slave port of the real-time clock: framing, pointer, carry hold, watchdog
`timescale 1ns/1ps
// Functional notes
// - lines idle high; SDA fall with SCL high opens, SDA rise with SCL high closes.
// - bytes are 8 bits; the receiver pulls SDA low on the ninth clock.
// - receiver releases SDA at ninth falling edge unless it starts transmitting.
// - master withholds acknowledge on the last read byte; device keeps SDA released.
// - first byte is 7-bit address MSB first, then direction bit, high means read.
// - respond only to slave address 0110010.
// - start without stop is repeated start; take a new address byte and continue.
// - second write byte splits into 4-bit pointer and 4-bit format field.
// - write format is 0000; third byte goes to the register at the pointer.
// - pointer advances by one per byte from the fourth on, wrapping F to 0.
// - every stop loads the pointer with F.
// - read method one: write pointer, repeated start with read bit, read from pointer.
// - format 4 switches to transmitting right after the pointer byte.
// - read right after start returns data from current pointer, F after stop.
// - hold timekeeping carries from start to stop; apply within about 61 us after.
// - after 0.5 to 1.0 s without stop, end the access as a stop would.
// - timeout runs from the first start; repeated starts do not restart it.
// - after timeout, written bytes get no acknowledge and reads return FF.
module rtc_i2c_slave
   import rtc_i2c_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       arst_n_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic       tick_2hz_in,
   output logic            carry_hold_out,
   output logic [3:0]      rd_addr_out,
   input  wire logic [7:0] rd_data_in,
   output logic            wr_valid_out,
   input  wire logic       wr_ready_in,
   output logic [3:0]      wr_addr_out,
   output logic [7:0]      wr_data_out
);
   logic [2:0]  scl_s;
   logic [2:0]  sda_s;
   logic        scl_f;
   logic        sda_f;
   logic        scl_q;
   logic        sda_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_ev;
   logic        stop_ev;
   link_state_e state;
   logic [3:0]  bit_cnt;
   logic [7:0]  sh;
   logic [7:0]  tx_byte;
   logic        rw;
   logic        want_ptr;
   logic        tx_next;
   logic        acked;
   logic        access_open;
   logic        timed_out;
   logic [1:0]  tick_cnt;
   logic        timeout_fire;
   logic        rx_done;
   logic        tx_done;
   logic        rx_ack;
   logic        push;
   logic        buf_ready;
   logic [7:0]  load_byte;

   // three-stage synchroniser; a level counts once stages two and three agree
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
         if (scl_s[1] == scl_s[2]) begin
            scl_f <= scl_s[2];
         end
         if (sda_s[1] == sda_s[2]) begin
            sda_f <= sda_s[2];
         end
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   assign scl_rise = scl_f && !scl_q;
   assign scl_fall = !scl_f && scl_q;
   assign start_ev = scl_f && scl_q && sda_q && !sda_f;
   assign stop_ev  = scl_f && scl_q && !sda_q && sda_f;

   assign rx_done      = (state == ST_RX) && scl_fall && (bit_cnt == BYTE_BITS);
   assign tx_done      = (state == ST_TX) && scl_fall && (bit_cnt == LAST_TX_BIT);
   // a full buffer refuses the byte with no acknowledge rather than lose it
   assign rx_ack       = !timed_out && (want_ptr || buf_ready);
   assign push         = rx_done && !want_ptr && rx_ack;
   assign timeout_fire = access_open && tick_2hz_in && (tick_cnt == TIMEOUT_TICKS - 2'h1);
   assign load_byte    = timed_out ? TIMEOUT_FILL : rd_data_in;

   // the open-drain stage only ever pulls low
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // byte framing and acknowledge
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state      <= ST_IDLE;
         bit_cnt    <= 4'h0;
         sh         <= 8'h00;
         tx_byte    <= 8'hff;
         rw         <= 1'b0;
         want_ptr   <= 1'b0;
         tx_next    <= 1'b0;
         acked      <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (stop_ev) begin
         state      <= ST_IDLE;
         sda_oe_out <= 1'b0;
      end else if (start_ev) begin
         state      <= ST_ADDR;
         bit_cnt    <= 4'h0;
         sda_oe_out <= 1'b0;
      end else begin
         unique case (state)
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  sh      <= {sh[6:0], sda_f};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                  bit_cnt <= 4'h0;
                  if (state == ST_ADDR) begin
                     if (sh[7:1] == SLAVE_ADDR) begin
                        rw         <= sh[0];
                        want_ptr   <= !sh[0];
                        sda_oe_out <= 1'b1;
                        state      <= ST_ADDR_ACK;
                     end else begin
                        state <= ST_IGNORE;
                     end
                  end else begin
                     want_ptr   <= 1'b0;
                     tx_next    <= want_ptr && (sh[3:0] == FMT_READ_NOW);
                     sda_oe_out <= rx_ack;
                     state      <= rx_ack ? ST_RX_ACK : ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK, ST_RX_ACK: begin
               if (scl_fall) begin
                  if ((state == ST_ADDR_ACK && rw) || (state == ST_RX_ACK && tx_next)) begin
                     tx_byte    <= load_byte;
                     sda_oe_out <= !load_byte[7];
                     state      <= ST_TX;
                  end else begin
                     sda_oe_out <= 1'b0;
                     state      <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (tx_done) begin
                  bit_cnt    <= 4'h0;
                  sda_oe_out <= 1'b0;
                  state      <= ST_TX_ACK;
               end else if (scl_fall) begin
                  bit_cnt    <= bit_cnt + 4'h1;
                  tx_byte    <= {tx_byte[6:0], 1'b1};
                  sda_oe_out <= !tx_byte[6];
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  acked <= !sda_f;
               end else if (scl_fall) begin
                  if (acked) begin
                     tx_byte    <= load_byte;
                     sda_oe_out <= !load_byte[7];
                     state      <= ST_TX;
                  end else begin
                     state <= ST_IGNORE;
                  end
               end
            end
            ST_IDLE, ST_IGNORE: ;
         endcase
      end
   end

   // internal address pointer; also the read address toward the register file
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_addr_out <= PTR_AFTER_STOP;
      end else if (stop_ev || timeout_fire) begin
         rd_addr_out <= PTR_AFTER_STOP;
      end else if (rx_done && want_ptr && rx_ack) begin
         rd_addr_out <= sh[7:4];
      end else if (push || tx_done) begin
         rd_addr_out <= rd_addr_out + 4'h1;
      end
   end

   // access window, carry hold and watchdog
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         access_open <= 1'b0;
         timed_out   <= 1'b0;
         tick_cnt    <= 2'h0;
      end else if (stop_ev) begin
         access_open <= 1'b0;
         tick_cnt    <= 2'h0;
      end else if (start_ev && !access_open) begin
         access_open <= 1'b1;
         timed_out   <= 1'b0;
         tick_cnt    <= 2'h0;
      end else if (timeout_fire) begin
         access_open <= 1'b0;
         timed_out   <= 1'b1;
         tick_cnt    <= 2'h0;
      end else if (access_open && tick_2hz_in) begin
         tick_cnt <= tick_cnt + 2'h1;
      end
   end

   // carries resume the cycle after the access closes, well inside 61 us
   assign carry_hold_out = access_open;

   pair_buffer #(
      .W(WR_W)
   ) u_wr_buf (
      .sys_clk_in    (sys_clk_in),
      .arst_n_in     (arst_n_in),
      .in_valid_in   (push),
      .in_ready_out  (buf_ready),
      .in_data_in    ({rd_addr_out, sh}),
      .out_valid_out (wr_valid_out),
      .out_ready_in  (wr_ready_in),
      .out_data_out  ({wr_addr_out, wr_data_out})
   );

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   property p_stop_closes;
      stop_ev |=> !carry_hold_out && rd_addr_out == PTR_AFTER_STOP && state == ST_IDLE;
   endproperty
   a_stop_closes: assert property (p_stop_closes) else $error("stop did not close access");

   property p_first_start;
      start_ev && !access_open |=> carry_hold_out && tick_cnt == 2'h0 && !timed_out;
   endproperty
   a_first_start: assert property (p_first_start) else $error("first start did not open access");

   property p_rep_start_keeps_timer;
      start_ev && access_open && !tick_2hz_in |=> carry_hold_out && tick_cnt == $past(tick_cnt);
   endproperty
   a_rep_start_keeps_timer: assert property (p_rep_start_keeps_timer) else $error("timer restarted");

   property p_timeout;
      timeout_fire && !stop_ev |=> !carry_hold_out && timed_out && rd_addr_out == PTR_AFTER_STOP;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout did not release access");

   property p_addr_match;
      state == ST_ADDR && scl_fall && bit_cnt == BYTE_BITS && sh[7:1] == SLAVE_ADDR
         |=> sda_oe_out && state == ST_ADDR_ACK;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("own address not acknowledged");

   property p_addr_miss;
      state == ST_ADDR && scl_fall && bit_cnt == BYTE_BITS && sh[7:1] != SLAVE_ADDR
         |=> !sda_oe_out && state == ST_IGNORE;
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

   property p_open_drain;
      sda_oe_out |-> !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda driven high");

   property p_drive_on_low_clock;
      $rose(sda_oe_out) |-> !scl_f;
   endproperty
   a_drive_on_low_clock: assert property (p_drive_on_low_clock) else $error("sda pulled while scl high");

   property p_nack_after_timeout;
      rx_done && timed_out |=> !sda_oe_out;
   endproperty
   a_nack_after_timeout: assert property (p_nack_after_timeout) else $error("byte acked after timeout");

   property p_release_ninth;
      state == ST_RX_ACK && scl_fall && !tx_next |=> !sda_oe_out && state == ST_RX;
   endproperty
   a_release_ninth: assert property (p_release_ninth) else $error("sda held after ninth clock");

   property p_ptr_step;
      tx_done && !timeout_fire |=> rd_addr_out == $past(rd_addr_out) + 4'h1;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

   c_write_push: cover property (push);
   c_read_byte: cover property (tx_done);
   c_read_now: cover property (state == ST_RX_ACK && scl_fall && tx_next);
   c_timeout: cover property (timeout_fire);
endmodule

// file: tb/i2c_master_model.sv
// behavioural two-wire bus master that drives the rtc slave port
`timescale 1ns/1ps
module i2c_master_model (
   output logic      scl_out,
   output logic      sda_low_out,
   input  wire logic sda_in
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // only this side frames an access; scl stands high between frames
   task automatic start_cond();
      if (!scl_out) begin
         #45 sda_low_out = 1'b0;
         #65 scl_out = 1'b1;
      end
      #80 sda_low_out = 1'b1;
      #80 scl_out = 1'b0;
   endtask
   task automatic stop_cond();
      #45 sda_low_out = 1'b1;
      #65 scl_out = 1'b1;
      #80 sda_low_out = 1'b0;
      #61000;
   endtask
   // low phase of 110 ns outlasts the slave's answer, which lands up to five clocks after scl falls
   task automatic bit_io(input logic b, output logic r);
      #45 sda_low_out = !b;
      #65 scl_out = 1'b1;
      #40 r = sda_in;
      #10 scl_out = 1'b0;
   endtask
   // msb first, then the ninth clock; a read sends ff so the wire stays released
   task automatic xfer(input logic [7:0] d, input logic ninth_in, output logic [7:0] q, output logic ninth);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ninth_in, ninth);
   endtask
endmodule

// file: tb/rtc_i2c_slave_interface_test.sv
// self-checking bench for the rtc two-wire slave port
`timescale 1ns/1ps
module rtc_i2c_slave_interface_test;
   import rtc_i2c_pkg::*;
   logic        sys_clk;
   logic        arst_n;
   logic        scl;
   logic        m_low;
   wire         sda_wire;
   logic        sda_out;
   logic        sda_oe;
   logic        tick;
   logic        carry;
   logic [3:0]  rd_addr;
   logic [7:0]  rd_data;
   logic        wr_valid;
   logic        wr_ready;
   logic [3:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        stall;
   logic [31:0] lfsr = 32'he2e1;
   int          bad_count;
   int          n_checks;
   logic [11:0] exp_q[$];

   // pull-up on the wire: low only while someone pulls it
   assign sda_wire = !m_low && (sda_oe ? sda_out : 1'b1);

   i2c_master_model m (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda_wire));

   rtc_i2c_slave dut (
      .sys_clk_in(sys_clk), .arst_n_in(arst_n), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe_out(sda_oe), .tick_2hz_in(tick), .carry_hold_out(carry),
      .rd_addr_out(rd_addr), .rd_data_in(rd_data), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready),
      .wr_addr_out(wr_addr), .wr_data_out(wr_data)
   );

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   // register file stand-in: content tells which address was read
   always @(posedge sys_clk) begin
      lfsr <= lfsr_next(lfsr);
      rd_data <= {4'ha, rd_addr};
      wr_ready <= !stall && lfsr[0];
   end

   task automatic end_sim();
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t write word %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t byte %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t flag %b want %b", $time, got, exp);
      end
   endtask

   // oldest noted write word against whatever the buffer hands over
   always @(posedge sys_clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
         chk_word({wr_addr, wr_data}, (exp_q.size() > 0) ? exp_q.pop_front() : 12'hxxx);
   end

   task automatic wr(input logic [7:0] d, input logic ack_n);
      logic [7:0] q;
      logic       a;
      m.xfer(d, 1'b1, q, a);
      chk_bit(a, ack_n);
   endtask

   task automatic rd(input logic [7:0] exp, input logic last);
      logic [7:0] q;
      logic       a;
      m.xfer(8'hff, last, q, a);
      chk_byte(q, exp);
   endtask

   task automatic wdata(input logic [3:0] a);
      logic [7:0] d;
      d = lfsr[15:8];
      exp_q.push_back({a, d});
      wr(d, 1'b0);
   endtask

   task automatic pulse();
      @(posedge sys_clk) tick <= 1'b1;
      @(posedge sys_clk) tick <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   initial begin
      #1_500_000;
      bad_count++;
      end_sim();
   end

   initial begin
      logic [7:0] q;
      logic       a;
      static logic [7:0] foreign[4] = '{8'h66, 8'he4, 8'h24, 8'h67};
      arst_n = 1'b0;
      tick = 1'b0;
      stall = 1'b0;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk_byte({4'h0, rd_addr}, 8'h0f);
      // write across the pointer wrap
      m.start_cond();
      wr(8'h64, 1'b0);
      chk_bit(carry, 1'b1);
      wr(8'he0, 1'b0);
      wdata(4'he);
      wdata(4'hf);
      wdata(4'h0);
      m.stop_cond();
      chk_bit(carry, 1'b0);
      chk_byte({4'h0, rd_addr}, 8'h0f);
      // pointer write, repeated start, read
      m.start_cond();
      wr(8'h64, 1'b0);
      wr(8'h20, 1'b0);
      m.start_cond();
      wr(8'h65, 1'b0);
      rd(8'ha2, 1'b0);
      rd(8'ha3, 1'b0);
      rd(8'ha4, 1'b1);
      m.stop_cond();
      // immediate read after pointer byte
      m.start_cond();
      wr(8'h64, 1'b0);
      wr(8'he4, 1'b0);
      rd(8'hae, 1'b0);
      rd(8'haf, 1'b0);
      rd(8'ha0, 1'b1);
      m.stop_cond();
      // read straight after the address byte
      m.start_cond();
      wr(8'h65, 1'b0);
      rd(8'haf, 1'b0);
      rd(8'ha0, 1'b1);
      m.stop_cond();
      foreach (foreign[i]) begin
         m.start_cond();
         wr(foreign[i], 1'b1);
         wr(8'h10, 1'b1);
         m.stop_cond();
      end
      // consumer stalls: third data byte is refused and the pointer holds
      @(posedge sys_clk) stall <= 1'b1;
      repeat (3) @(posedge sys_clk);
      m.start_cond();
      wr(8'h64, 1'b0);
      wr(8'h50, 1'b0);
      wdata(4'h5);
      wdata(4'h6);
      wr(8'h77, 1'b1);
      chk_byte({4'h0, rd_addr}, 8'h07);
      m.stop_cond();
      // a refused byte ends the access, so the last word goes in a fresh one
      @(posedge sys_clk) stall <= 1'b0;
      m.start_cond();
      wr(8'h64, 1'b0);
      wr(8'h70, 1'b0);
      wdata(4'h7);
      m.stop_cond();
      // watchdog runs from the first start, not the repeated one
      m.start_cond();
      wr(8'h64, 1'b0);
      pulse();
      chk_bit(carry, 1'b1);
      m.start_cond();
      wr(8'h65, 1'b0);
      rd(8'haf, 1'b0);
      pulse();
      chk_bit(carry, 1'b0);
      // byte already loaded before the release is not judged
      m.xfer(8'hff, 1'b0, q, a);
      rd(8'hff, 1'b1);
      m.stop_cond();
      m.start_cond();
      wr(8'h64, 1'b0);
      pulse();
      pulse();
      wr(8'h30, 1'b1);
      m.stop_cond();
      repeat (20) @(posedge sys_clk);
      chk_bit(exp_q.size() == 0, 1'b1);
      end_sim();
   end
endmodule
